// *** src/host_port_status_consts.svh ***
// constants for the host port status word block
`ifndef HOST_PORT_STATUS_CONSTS_SVH
`define HOST_PORT_STATUS_CONSTS_SVH
`define BIT_SUPPLY_VALID 15
`define BIT_ID_LEVEL 14
`define BIT_RSVD13 13
`define BIT_FRAME_P2 12
`define BIT_RSVD11 11
`define BIT_FRAME_P1 10
`define BIT_RESET_P2 9
`define BIT_MBOX_IN 8
`define BIT_WAKE_P2 7
`define BIT_WAKE_P1 6
`define BIT_NOTE_P2 5
`define BIT_NOTE_P1 4
`define BIT_DONE_P2 3
`define BIT_DONE_P1 2
`define BIT_RESET_P1 1
`define BIT_MBOX_OUT 0
`define NOTE_P1_OFFSET 16'h0144
`define NOTE_P2_OFFSET 16'h0148
`define ROUTE_FRAME_P2 13
`define ROUTE_FRAME_P1 11
`define ROUTE_RESET_P2 9
`define ROUTE_WAKE_P2 7
`define ROUTE_WAKE_P1 6
`define ROUTE_DONE_P2 3
`define ROUTE_DONE_P1 2
`define ROUTE_RESET_P1 1
`define WORD_ZERO 16'h0000
`define SUPPLY_SETTLE_NS 10000
`define SYS_PERIOD_NS 10
`endif

// *** src/host_port_status_flags.sv ***
// status word of the parallel host link with mailbox and message flags
`timescale 1ns/1ns
`default_nettype none
`include "host_port_status_consts.svh"
module host_port_status_flags
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic supplyAboveRaw,
    input wire logic otgIdentityPinLevelRaw,
    input wire logic [7:0] engineIrq,
    input wire logic [15:0] routeToHost,
    input wire logic hostStatusRead,
    input wire logic hostMailboxWrite,
    input wire logic hostMailboxRead,
    input wire logic hostNoteRead1,
    input wire logic hostNoteRead2,
    input wire host_port_status_pkg::word_t hostData,
    input wire logic cpuMailboxWrite,
    input wire logic cpuMailboxRead,
    input wire logic cpuNoteWrite,
    input wire logic [15:0] cpuAddr,
    input wire host_port_status_pkg::word_t cpuData,
    output logic [15:0] hostStatusWord,
    output logic [15:0] mailboxWord,
    output logic [15:0] notePort1,
    output logic [15:0] notePort2,
    output logic hostAttentionIrq
);
    import host_port_status_pkg::*;

    // engineIrq lanes: 0 frame1 1 frame2 2 reset1 3 reset2 4 wake1 5 wake2 6 done1 7 done2
    typedef struct packed {
        logic [1:0] supplySync;
        logic [1:0] idSync;
        word_t status;
        word_t mailbox;
        word_t note1;
        word_t note2;
        logic mboxIn;
        logic mboxOut;
        logic attention;
        logic irqOut;
    } state_s;
    state_s state_reg;
    state_s state_next;

    logic note1Flag;
    logic note2Flag;
    logic note1Write;
    logic note2Write;
    logic [7:0] routed;

    // note writes decode on the note word offsets
    assign note1Write = cpuNoteWrite && (cpuAddr == `NOTE_P1_OFFSET);
    assign note2Write = cpuNoteWrite && (cpuAddr == `NOTE_P2_OFFSET);

    // =====================================
    // message flags
    note_flag uNote1 (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .setPulse(note1Write),
        .clearPulse(hostNoteRead1),
        .flag(note1Flag)
    );
    note_flag uNote2 (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .setPulse(note2Write),
        .clearPulse(hostNoteRead2),
        .flag(note2Flag)
    );

    // =====================================
    // routing gate for engine interrupts
    assign routed[0] = engineIrq[0] & routeToHost[`ROUTE_FRAME_P1];
    assign routed[1] = engineIrq[1] & routeToHost[`ROUTE_FRAME_P2];
    assign routed[2] = engineIrq[2] & routeToHost[`ROUTE_RESET_P1];
    assign routed[3] = engineIrq[3] & routeToHost[`ROUTE_RESET_P2];
    assign routed[4] = engineIrq[4] & routeToHost[`ROUTE_WAKE_P1];
    assign routed[5] = engineIrq[5] & routeToHost[`ROUTE_WAKE_P2];
    assign routed[6] = engineIrq[6] & routeToHost[`ROUTE_DONE_P1];
    assign routed[7] = engineIrq[7] & routeToHost[`ROUTE_DONE_P2];

    // =====================================
    // next state: status assembly is independent of any memory access
    always_comb
    begin
        state_next = state_reg;
        state_next.supplySync = {state_reg.supplySync[0], supplyAboveRaw};
        state_next.idSync = {state_reg.idSync[0], otgIdentityPinLevelRaw};
        // mailbox data and in flag, set wins over clear
        if (hostMailboxWrite)
            state_next.mailbox = hostData;
        else if (cpuMailboxWrite)
            state_next.mailbox = cpuData;
        if (hostMailboxWrite)
            state_next.mboxIn = 1'b1;
        else if (cpuMailboxRead)
            state_next.mboxIn = 1'b0;
        if (cpuMailboxWrite)
            state_next.mboxOut = 1'b1;
        else if (hostMailboxRead)
            state_next.mboxOut = 1'b0;
        // attention line
        if (cpuMailboxWrite || note1Write || note2Write)
            state_next.attention = 1'b1;
        else if (hostMailboxRead)
            state_next.attention = 1'b0;
        // interrupt output: sticky attention or any routed engine interrupt
        state_next.irqOut = state_next.attention | (|routed);
        // note words keep whatever was last written
        if (note1Write)
            state_next.note1 = cpuData;
        if (note2Write)
            state_next.note2 = cpuData;
        // status word, only the host port sees it
        state_next.status = `WORD_ZERO;
        state_next.status[`BIT_SUPPLY_VALID] = state_reg.supplySync[1];
        state_next.status[`BIT_ID_LEVEL] = state_reg.idSync[1];
        state_next.status[`BIT_FRAME_P2] = routed[1];
        state_next.status[`BIT_FRAME_P1] = routed[0];
        state_next.status[`BIT_RESET_P2] = routed[3];
        state_next.status[`BIT_RESET_P1] = routed[2];
        state_next.status[`BIT_MBOX_IN] = state_next.mboxIn;
        state_next.status[`BIT_WAKE_P2] = routed[5];
        state_next.status[`BIT_WAKE_P1] = routed[4];
        state_next.status[`BIT_NOTE_P2] = note2Flag;
        state_next.status[`BIT_NOTE_P1] = note1Flag;
        state_next.status[`BIT_DONE_P2] = routed[7];
        state_next.status[`BIT_DONE_P1] = routed[6];
        state_next.status[`BIT_MBOX_OUT] = state_next.mboxOut;
    end

    // state register; note words reset to zero as a defined value
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            state_reg <= '0;
        else
            state_reg <= state_next;
    end

    // outputs straight from flip-flops, no CPU read path exists
    assign hostStatusWord = state_reg.status;
    assign mailboxWord = state_reg.mailbox;
    assign notePort1 = state_reg.note1;
    assign notePort2 = state_reg.note2;
    assign hostAttentionIrq = state_reg.irqOut;

    // =====================================
    // checks: mailbox handshake steps as named sequences
    sequence mboxWrite;
        hostMailboxWrite;
    endsequence
    sequence cpuTakes;
        cpuMailboxRead && !hostMailboxWrite;
    endsequence
    sequence hostTakes;
        hostMailboxRead && !cpuMailboxWrite;
    endsequence

    // synchronised pins reach the status word after three edges
    AST_SUPPLY: assert property (@(posedge sys_clk) disable iff (!nrst)
        supplyAboveRaw [*4] |-> hostStatusWord[`BIT_SUPPLY_VALID]) else $error("supply flag wrong");
    AST_ID: assert property (@(posedge sys_clk) disable iff (!nrst)
        !otgIdentityPinLevelRaw [*4] |-> !hostStatusWord[`BIT_ID_LEVEL]) else $error("otg_identity_pin_level wrong");
    // routing gate on status bits and interrupt output
    AST_ROUTE: assert property (@(posedge sys_clk) disable iff (!nrst)
        !routeToHost[`ROUTE_FRAME_P1] |=> !hostStatusWord[`BIT_FRAME_P1]) else $error("unrouted frame shown");
    AST_WAKE_ROUTE: assert property (@(posedge sys_clk) disable iff (!nrst)
        !routeToHost[`ROUTE_WAKE_P2] |=> !hostStatusWord[`BIT_WAKE_P2]) else $error("unrouted wake shown");
    AST_IRQ_ROUTED: assert property (@(posedge sys_clk) disable iff (!nrst)
        (engineIrq[0] && routeToHost[`ROUTE_FRAME_P1]) |=> hostAttentionIrq) else $error("routed frame no irq");
    AST_DONE: assert property (@(posedge sys_clk) disable iff (!nrst)
        (engineIrq[7] && routeToHost[`ROUTE_DONE_P2]) |=> hostStatusWord[`BIT_DONE_P2]) else $error("done2 lost");
    // mailbox flags and attention
    AST_MBOX_IN: assert property (@(posedge sys_clk) disable iff (!nrst)
        mboxWrite |=> hostStatusWord[`BIT_MBOX_IN] && mailboxWord == $past(hostData)) else $error("mailbox in wrong");
    AST_MBOX_CLR: assert property (@(posedge sys_clk) disable iff (!nrst)
        cpuTakes |=> !hostStatusWord[`BIT_MBOX_IN]) else $error("mailbox in not cleared");
    AST_MBOX_OUT: assert property (@(posedge sys_clk) disable iff (!nrst)
        cpuMailboxWrite |=> hostStatusWord[`BIT_MBOX_OUT] && hostAttentionIrq) else $error("mailbox out wrong");
    AST_MBOX_OUT_CLR: assert property (@(posedge sys_clk) disable iff (!nrst)
        hostTakes |=> !hostStatusWord[`BIT_MBOX_OUT]) else $error("mailbox out not cleared");
    AST_ATTN_DROP: assert property (@(posedge sys_clk) disable iff (!nrst)
        (hostMailboxRead && !cpuMailboxWrite && !cpuNoteWrite) |=> !state_reg.attention) else $error("attention held");
    // a status poll has no side effect on the flags
    AST_POLL_FREE: assert property (@(posedge sys_clk) disable iff (!nrst)
        (hostStatusRead && !hostMailboxRead && !cpuMailboxWrite)
        |=> hostStatusWord[`BIT_MBOX_OUT] == $past(hostStatusWord[`BIT_MBOX_OUT])) else $error("poll changed flag");
    // note flags show one cycle after the flag itself
    AST_NOTE: assert property (@(posedge sys_clk) disable iff (!nrst)
        note1Write |=> ##1 hostStatusWord[`BIT_NOTE_P1]) else $error("note flag missing");
    AST_NOTE2: assert property (@(posedge sys_clk) disable iff (!nrst)
        note2Write |=> ##1 hostStatusWord[`BIT_NOTE_P2]) else $error("note2 flag missing");
    AST_NOTE_IRQ: assert property (@(posedge sys_clk) disable iff (!nrst)
        (note1Write || note2Write) |=> hostAttentionIrq) else $error("note write no irq");
    AST_NOTE_CLR: assert property (@(posedge sys_clk) disable iff (!nrst)
        (hostNoteRead1 && !note1Write) |=> ##1 !hostStatusWord[`BIT_NOTE_P1]) else $error("note1 flag not cleared");
    AST_RSVD: assert property (@(posedge sys_clk) disable iff (!nrst)
        !hostStatusWord[`BIT_RSVD13] && !hostStatusWord[`BIT_RSVD11]) else $error("reserved bit set");
endmodule
`default_nettype wire

// *** src/host_port_status_pkg.sv ***
// types for the host port status word block
package host_port_status_pkg;
    typedef logic [15:0] word_t;
    typedef enum logic [1:0] {
        NOTE_IDLE = 2'b00,
        NOTE_PENDING = 2'b01
    } note_state_e;
endpackage

// *** src/note_flag.sv ***
// one sticky message flag: set by a write, cleared by a read, set wins
`timescale 1ns/1ns
`default_nettype none
module note_flag
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic setPulse,
    input wire logic clearPulse,
    output logic flag
);
    import host_port_status_pkg::*;

    typedef struct packed {
        note_state_e st;
    } state_s;
    state_s state_reg;
    state_s state_next;

    // =====================================
    // next state
    always_comb
    begin
        state_next = state_reg;
        case (state_reg.st)
            NOTE_IDLE:
            begin
                if (setPulse)
                    state_next.st = NOTE_PENDING;
            end
            NOTE_PENDING:
            begin
                if (clearPulse && !setPulse)
                    state_next.st = NOTE_IDLE;
            end
            default: state_next.st = NOTE_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            state_reg <= '{st: NOTE_IDLE};
        else
            state_reg <= state_next;
    end

    assign flag = (state_reg.st == NOTE_PENDING);

    AST_SET_WINS: assert property (@(posedge sys_clk) disable iff (!nrst)
        setPulse |=> flag) else $error("flag not set after write");
    AST_CLEAR: assert property (@(posedge sys_clk) disable iff (!nrst)
        (clearPulse && !setPulse) |=> !flag) else $error("flag not cleared by read");
endmodule
`default_nettype wire

// *** verification/host_port_host_model.sv ***
// behavioural external host that drives the host side strobes
`timescale 1ns/1ns
`default_nettype none
module host_port_host_model
(
    input wire logic sys_clk,
    output logic statusRd,
    output logic mbWr,
    output logic mbRd,
    output logic noteRd1,
    output logic noteRd2,
    output logic [15:0] data
);
    // idle host: no strobe, bus at rest
    initial
    begin
        {statusRd, mbWr, mbRd, noteRd1, noteRd2} = 5'h00;
        data = 16'h0000;
    end
    // one-cycle strobe launched at the falling edge; released data is inverted
    task automatic pulse(input int kind, input logic [15:0] d);
        @(negedge sys_clk);
        data = d;
        case (kind)
            0: statusRd = 1'b1;
            1: mbWr = 1'b1;
            2: mbRd = 1'b1;
            3: noteRd1 = 1'b1;
            default: noteRd2 = 1'b1;
        endcase
        @(negedge sys_clk);
        {statusRd, mbWr, mbRd, noteRd1, noteRd2} = 5'h00;
        data = ~d;
    endtask
endmodule
`default_nettype wire

// *** verification/host_port_status_flags_tb_top.sv ***
// self-checking bench for the host port status word
`timescale 1ns/1ns
`default_nettype none
`include "host_port_status_consts.svh"
module host_port_status_flags_tb_top;
    import host_port_status_pkg::*;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic supplyRaw = 1'b0;
    logic idRaw = 1'b0;
    logic [7:0] engineIrq = 8'h00;
    logic [15:0] route = 16'h0000;
    logic cpuMbWr = 1'b0;
    logic cpuMbRd = 1'b0;
    logic cpuNoteWr = 1'b0;
    logic [15:0] cpuAddr = 16'h0000;
    word_t cpuData = 16'h0000;
    wire logic statusRd, mbWr, mbRd, noteRd1, noteRd2;
    wire logic [15:0] hostData;
    logic [15:0] status, mbox, note1, note2;
    logic irq;
    int num_errors = 0;
    int total_checks = 0;
    int cycles = 0;
    int bitOf [8] = '{`BIT_FRAME_P1, `BIT_FRAME_P2, `BIT_RESET_P1, `BIT_RESET_P2,
        `BIT_WAKE_P1, `BIT_WAKE_P2, `BIT_DONE_P1, `BIT_DONE_P2};
    int routeOf [8] = '{`ROUTE_FRAME_P1, `ROUTE_FRAME_P2, `ROUTE_RESET_P1, `ROUTE_RESET_P2,
        `ROUTE_WAKE_P1, `ROUTE_WAKE_P2, `ROUTE_DONE_P1, `ROUTE_DONE_P2};
    // ==================== harness ====================
    host_port_host_model host (.sys_clk(sys_clk), .statusRd(statusRd), .mbWr(mbWr), .mbRd(mbRd),
        .noteRd1(noteRd1), .noteRd2(noteRd2), .data(hostData));
    host_port_status_flags dut (.sys_clk(sys_clk), .nrst(nrst), .supplyAboveRaw(supplyRaw),
        .otgIdentityPinLevelRaw(idRaw), .engineIrq(engineIrq), .routeToHost(route),
        .hostStatusRead(statusRd), .hostMailboxWrite(mbWr), .hostMailboxRead(mbRd),
        .hostNoteRead1(noteRd1), .hostNoteRead2(noteRd2), .hostData(hostData),
        .cpuMailboxWrite(cpuMbWr), .cpuMailboxRead(cpuMbRd), .cpuNoteWrite(cpuNoteWr),
        .cpuAddr(cpuAddr), .cpuData(cpuData), .hostStatusWord(status), .mailboxWord(mbox),
        .notePort1(note1), .notePort2(note2), .hostAttentionIrq(irq));
    // free-running 100 MHz clock
    initial
    begin
        forever #5 sys_clk = ~sys_clk;
    end
    // hang guard
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            num_errors++;
            end_sim();
        end
    end
    // ==================== helpers ====================
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    // one-cycle CPU strobe: 0 mailbox write, 1 mailbox read, 2 note write
    task automatic cpu(input int kind, input logic [15:0] a, input logic [15:0] d);
        @(negedge sys_clk);
        cpuAddr = a;
        cpuData = d;
        cpuMbWr = (kind == 0);
        cpuMbRd = (kind == 1);
        cpuNoteWr = (kind == 2);
        @(negedge sys_clk);
        {cpuMbWr, cpuMbRd, cpuNoteWr} = 3'b000;
        cpuData = ~d;
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // ==================== scenarios ====================
    task automatic t_reset();
        check(status, 16'h0000);
        check(mbox, 16'h0000);
        check(irq, 1'b0);
    endtask
    task automatic t_cpu_mbox();
        cpu(0, 16'h0000, 16'ha5c3);
        check(mbox, 16'ha5c3);
        check(status[0], 1'b1);
        check(irq, 1'b1);
        host.pulse(0, 16'h0000);
        check(status[0], 1'b1);
        host.pulse(2, 16'h0000);
        check(status[0], 1'b0);
        check(irq, 1'b0);
    endtask
    task automatic t_host_mbox();
        host.pulse(1, 16'h5a3c);
        check(mbox, 16'h5a3c);
        check(status[8], 1'b1);
        check(irq, 1'b0);
        cpu(1, 16'h0000, 16'h0000);
        check(status[8], 1'b0);
        check(mbox, 16'h5a3c);
    endtask
    task automatic t_notes();
        cpu(2, 16'h0146, 16'h1234);
        settle(1);
        check(status[5:4], 2'b00);
        check(irq, 1'b0);
        check(note1, 16'h0000);
        check(note2, 16'h0000);
        cpu(2, `NOTE_P1_OFFSET, 16'h0f1e);
        cpu(2, `NOTE_P2_OFFSET, 16'h8001);
        settle(1);
        check(status[5:4], 2'b11);
        check(note1, 16'h0f1e);
        check(note2, 16'h8001);
        check(irq, 1'b1);
        host.pulse(3, 16'h0000);
        settle(1);
        check(status[5:4], 2'b10);
        host.pulse(4, 16'h0000);
        settle(1);
        check(status[5:4], 2'b00);
        host.pulse(2, 16'h0000);
        check(irq, 1'b0);
    endtask
    // set and clear of note1, mailbox in or mailbox out in the same cycle: the set wins; of two mailbox writes the host data wins
    task automatic t_collide();
        fork
            cpu(2, `NOTE_P1_OFFSET, 16'h0000);
            host.pulse(3, 16'h0000);
        join
        settle(1);
        check(status[5:4], 2'b01);
        check(note1, 16'h0000);
        fork
            cpu(0, 16'h0000, 16'h1111);
            host.pulse(1, 16'h2222);
        join
        check(mbox, 16'h2222);
        check(status[8], 1'b1);
        check(status[0], 1'b1);
        check(irq, 1'b1);
        fork
            cpu(1, 16'h0000, 16'h0000);
            host.pulse(1, 16'h3333);
        join
        check(status[8], 1'b1);
        check(mbox, 16'h3333);
        fork
            cpu(0, 16'h0000, 16'h4444);
            host.pulse(2, 16'h0000);
        join
        check(status[0], 1'b1);
        check(irq, 1'b1);
        check(mbox, 16'h4444);
        cpu(1, 16'h0000, 16'h0000);
        host.pulse(2, 16'h0000);
        host.pulse(3, 16'h0000);
        settle(1);
        check(status, 16'h0000);
        check(irq, 1'b0);
    endtask
    task automatic t_engine();
        for (int i = 0; i < 8; i++)
        begin
            engineIrq = 8'h01 << i;
            route = 16'hffff ^ (16'h0001 << routeOf[i]);
            settle(1);
            check(status, 16'h0000);
            check(irq, 1'b0);
            route = 16'hffff;
            settle(1);
            check(status, 16'h0001 << bitOf[i]);
            check(irq, 1'b1);
        end
        engineIrq = 8'h00;
        route = 16'h0000;
        settle(1);
    endtask
    task automatic t_pins();
        supplyRaw = 1'b1;
        settle(`SUPPLY_SETTLE_NS / `SYS_PERIOD_NS);
        check(status[15], 1'b1);
        idRaw = 1'b1;
        supplyRaw = 1'b0;
        settle(3);
        check(status[15:14], 2'b01);
        idRaw = 1'b0;
        settle(3);
        check(status[14], 1'b0);
    endtask
    // main sequence: 12 cycles of reset, then every scenario
    initial
    begin
        settle(12);
        t_reset();
        nrst = 1'b1;
        t_cpu_mbox();
        t_host_mbox();
        t_notes();
        t_collide();
        t_engine();
        t_pins();
        end_sim();
    end
endmodule
`default_nettype wire
